// *** core/hf_osc_defines.vh ***
// Purpose: constants for the internal high-frequency oscillator control block
// Assumes: special-function register port with 8-bit addresses and data
// Notes:   offsets, field positions, reset values and timing counts
`ifndef HF_OSC_DEFINES_VH
`define HF_OSC_DEFINES_VH

`define HF_OSC_CONTROL_ADDR      8'hb2
`define HF_OSC_CALIBRATION_ADDR  8'hb3

`define CTRL_ENABLE_BIT          7
`define CTRL_READY_BIT           6
`define CTRL_SUSPEND_BIT         5
`define CTRL_DIV_HI              1
`define CTRL_DIV_LO              0
`define CAL_HI                   6

`define CTRL_RESET               8'hc0
`define CAL_RESET_DEFAULT        7'h40
`define DIV_RESET                2'h0

`define DIV_SEL_8                2'h0
`define DIV_SEL_4                2'h1
`define DIV_SEL_2                2'h2
`define DIV_SEL_1                2'h3

`define PRE_DIV_LOG2             2
`define SETTLE_TIME_NS           1000
`define CLK_PERIOD_NS            40
`define SETTLE_CYCLES            ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** core/clock_divider.v ***
// Purpose: fixed divide-by-4 prescaler followed by a 1/2/4/8 post-divider
// Assumes: runs on the oscillator clock, produces a clock-enable style tick
// Notes:   counter is frozen while the oscillator is stopped
`timescale 1ns/1ps
`include "hf_osc_defines.vh"

module clock_divider #(
    parameter CNT_W = 5
) (
    input  wire       ref_clk,   // oscillator clock
    input  wire       rst_n,     // synchronous reset, active low
    input  wire       run,       // oscillator running
    input  wire [1:0] div_sel,   // divider select field
    output reg        tick_q     // one-cycle system clock tick
);

    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] limit;

    // total division is 4 times the post-divider
    always @*
    begin
        case (div_sel)
            `DIV_SEL_8: limit = 5'h1f;
            `DIV_SEL_4: limit = 5'h0f;
            `DIV_SEL_2: limit = 5'h07;
            default:    limit = 5'h03;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt_q  <= {CNT_W{1'b0}};
            tick_q <= 1'b0;
        end
        else if (!run)
        begin
            tick_q <= 1'b0;
        end
        else if (cnt_q >= limit)
        begin
            cnt_q  <= {CNT_W{1'b0}};
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule // clock_divider

// *** core/hf_osc_control.v ***
// Purpose: control and status registers of the internal high-frequency oscillator
// Assumes: special-function register port, single clock, synchronous reset
// Notes:   system clock is delivered as a one-cycle tick plus a gated-run level
//
// Contract
// - after any reset the internal oscillator is the system clock source.
// - the 7-bit calibration field sets the period, zero fastest, all ones slowest.
// - the system clock passes a fixed divide by 4 then a 1/2/4/8 divider.
// - after reset the post-divider is 8, giving 1.5 MHz.
// - select 00 divides by 8, 01 by 4 and 10 by 2.
// - writing 1 to control bit 5 suspends the oscillator.
// - while suspended the clock stays stopped until an edge on the wake pin.
// - a wake edge resumes oscillator, cpu and peripherals where they left off.
// - control bit 7 enables the oscillator and resets to 1.
// - read-only bit 6 shows that the oscillator runs at its programmed frequency.
// - at reset the calibration loads the factory trim for 48 MHz.
// - control bits 4 to 2 and calibration bit 7 read zero and ignore writes.
`timescale 1ns/1ps
`include "hf_osc_defines.vh"

module hf_osc_control #(
    parameter [6:0] CAL_TRIM      = `CAL_RESET_DEFAULT, // factory trim, arbitrary default
    parameter       SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire       ref_clk,          // block clock
    input  wire       rst_n,            // synchronous reset, active low
    input  wire [7:0] sfr_addr,         // register address
    input  wire [7:0] sfr_wdata,        // write data
    input  wire       sfr_wr,           // write strobe
    input  wire       sfr_rd,           // read strobe
    output reg  [7:0] sfr_rdata_q,      // read data
    input  wire       wake_pin,         // external wake pin
    output wire       clk_sel_internal, // system clock source is the internal oscillator
    output wire       osc_run,          // oscillator running
    output wire [6:0] osc_trim,         // calibration to the analog core
    output wire       system_clock_tick // one-cycle system clock tick
);

    localparam ST_RUN     = 3'b001;
    localparam ST_SUSPEND = 3'b010;
    localparam ST_SETTLE  = 3'b100;

    reg  [2:0]  state_q;
    reg         osc_enable_bit_q;
    reg  [1:0]  clock_divider_select_q;
    reg  [6:0]  cal_q;
    reg         osc_freq_ready_flag_q;
    reg  [15:0] settle_cnt_q;
    reg         wake_s1_q;
    reg         wake_s2_q;
    reg         wake_s3_q;

    wire wr_ctrl = sfr_wr && (sfr_addr == `HF_OSC_CONTROL_ADDR);
    wire wr_cal  = sfr_wr && (sfr_addr == `HF_OSC_CALIBRATION_ADDR);
    wire wake_edge = wake_s2_q ^ wake_s3_q;
    // enable as it stands after this edge, so ready never lags a disable write
    wire en_next   = wr_ctrl ? sfr_wdata[`CTRL_ENABLE_BIT] : osc_enable_bit_q;

    assign clk_sel_internal = 1'b1;
    assign osc_trim = cal_q;
    assign osc_run  = osc_enable_bit_q && (state_q != ST_SUSPEND);

    // wake pin is asynchronous; first stage is read only by the second
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            osc_enable_bit_q       <= 1'b1;
            clock_divider_select_q <= `DIV_RESET;
            cal_q                  <= CAL_TRIM;
        end
        else
        begin
            if (wr_ctrl)
            begin
                osc_enable_bit_q       <= sfr_wdata[`CTRL_ENABLE_BIT];
                clock_divider_select_q <= sfr_wdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
            end
            // change is accepted at any time; settling restarts below
            if (wr_cal)
                cal_q <= sfr_wdata[`CAL_HI:0];
        end
    end

    // suspend and settle sequencing; ready drops while frequency is unsettled
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_q               <= ST_RUN;
            osc_freq_ready_flag_q <= 1'b1;
            settle_cnt_q          <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ST_RUN:
                begin
                    if (wr_ctrl && sfr_wdata[`CTRL_SUSPEND_BIT])
                    begin
                        state_q               <= ST_SUSPEND;
                        osc_freq_ready_flag_q <= 1'b0;
                    end
                    else if (wr_cal || (wr_ctrl && sfr_wdata[`CTRL_ENABLE_BIT]
                             && !osc_enable_bit_q))
                    begin
                        state_q               <= ST_SETTLE;
                        osc_freq_ready_flag_q <= 1'b0;
                        settle_cnt_q          <= 16'h0000;
                    end
                    else
                        osc_freq_ready_flag_q <= en_next;
                end
                ST_SUSPEND:
                begin
                    if (wake_edge)
                    begin
                        state_q      <= ST_SETTLE;
                        settle_cnt_q <= 16'h0000;
                    end
                end
                ST_SETTLE:
                begin
                    // a suspend request must not be lost while the frequency settles
                    if (wr_ctrl && sfr_wdata[`CTRL_SUSPEND_BIT])
                    begin
                        state_q               <= ST_SUSPEND;
                        osc_freq_ready_flag_q <= 1'b0;
                    end
                    else if (wr_cal || (wr_ctrl && sfr_wdata[`CTRL_ENABLE_BIT]
                             && !osc_enable_bit_q))
                        settle_cnt_q <= 16'h0000;
                    else if (settle_cnt_q >= SETTLE_CYCLES - 1)
                    begin
                        state_q               <= ST_RUN;
                        osc_freq_ready_flag_q <= en_next;
                    end
                    else
                        settle_cnt_q <= settle_cnt_q + 16'h0001;
                end
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            sfr_rdata_q <= 8'h00;
        else if (sfr_rd)
        begin
            if (sfr_addr == `HF_OSC_CONTROL_ADDR)
                sfr_rdata_q <= {osc_enable_bit_q, osc_freq_ready_flag_q,
                                (state_q == ST_SUSPEND), 3'b000,
                                clock_divider_select_q};
            else if (sfr_addr == `HF_OSC_CALIBRATION_ADDR)
                sfr_rdata_q <= {1'b0, cal_q};
            else
                sfr_rdata_q <= 8'h00;
        end
    end

    // cpu stalls because ticks stop while suspended
    clock_divider #(
        .CNT_W(5)
    ) u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (osc_run),
        .div_sel (clock_divider_select_q),
        .tick_q  (system_clock_tick)
    );

endmodule // hf_osc_control

// *** sim/hf_osc_control_asserts.sv ***
// Purpose: port assertions for the oscillator control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every hf_osc_control instance
`timescale 1ns/1ps
module hf_osc_control_asserts #(
    parameter [6:0] CAL_TRIM      = 7'h40,
    parameter       SETTLE_CYCLES = 25
) (
    input wire       ref_clk,          // clock
    input wire       rst_n,            // reset
    input wire [7:0] sfr_addr,         // address
    input wire [7:0] sfr_wdata,        // write data
    input wire       sfr_wr,           // write strobe
    input wire       sfr_rd,           // read strobe
    input wire [7:0] sfr_rdata_q,      // read data
    input wire       wake_pin,         // wake pin
    input wire       osc_run,          // running
    input wire [6:0] osc_trim,         // trim
    input wire       system_clock_tick // tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reg en_q; // last written enable bit; a disabled oscillator never wakes
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            en_q <= 1'b1;
        else if (sfr_wr && sfr_addr == 8'hb2)
            en_q <= sfr_wdata[7];
    end
    a_ctl_unused_zero: assert property (sfr_rd && sfr_addr == 8'hb2 |=> sfr_rdata_q[4:2] == 3'h0)
        else $error("unused control bits set");
    a_cal_read_back: assert property (sfr_rd && sfr_addr == 8'hb3 |=> sfr_rdata_q == {1'b0, $past(osc_trim)})
        else $error("calibration readback wrong");
    a_trim_write: assert property (sfr_wr && sfr_addr == 8'hb3 |=> osc_trim == $past(sfr_wdata[6:0]))
        else $error("trim not written");
    a_reset_trim: assert property ($rose(rst_n) |-> osc_trim == CAL_TRIM)
        else $error("trim reset value wrong");
    a_suspend_stops: assert property (sfr_wr && sfr_addr == 8'hb2 && sfr_wdata[5] |=> !osc_run)
        else $error("suspend did not stop");
    a_stopped_no_tick: assert property (!osc_run [*3] |-> !system_clock_tick)
        else $error("tick while stopped");
    a_tick_spacing: assert property (system_clock_tick |=> !system_clock_tick [*3])
        else $error("ticks too close");
    a_wake_resume: assert property ($changed(wake_pin) && en_q && !osc_run |-> ##[1:8] osc_run)
        else $error("no resume on wake");
    c_tick: cover property (system_clock_tick);
    c_wake: cover property ($changed(wake_pin) && !osc_run);
    c_cal_write: cover property (sfr_wr && sfr_addr == 8'hb3);
endmodule // hf_osc_control_asserts
bind hf_osc_control hf_osc_control_asserts #(.CAL_TRIM(CAL_TRIM), .SETTLE_CYCLES(SETTLE_CYCLES))
    hf_osc_control_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
    .wake_pin(wake_pin), .osc_run(osc_run), .osc_trim(osc_trim),
    .system_clock_tick(system_clock_tick));

// *** sim/tb_hf_osc_control.sv ***
// Purpose: self-checking bench for the oscillator control block
// Assumes: settle count cut to 3 cycles to keep the run short
// Notes: strobes last one cycle, read data checked the cycle after
`timescale 1ns/1ps
module tb_hf_osc_control;
    localparam [6:0] TRIM = 7'h40;
    reg        ref_clk, rst_n, sfr_wr, sfr_rd, wake_pin;
    reg  [7:0] sfr_addr, sfr_wdata, g;
    wire [7:0] sfr_rdata_q;
    wire [6:0] osc_trim;
    wire       clk_sel_internal, osc_run, system_clock_tick;
    integer    err_total, n_compared, n, d;
    hf_osc_control #(.CAL_TRIM(TRIM), .SETTLE_CYCLES(3)) hf_osc_control_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q), .wake_pin(wake_pin),
        .clk_sel_internal(clk_sel_internal), .osc_run(osc_run), .osc_trim(osc_trim),
        .system_clock_tick(system_clock_tick));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge ref_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= v;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
    begin
        @(posedge ref_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata_q, exp);
    end
    endtask
    // the first gap after a divider change may be partial, so the third is judged
    task per(input [7:0] exp);
    begin
        repeat (3)
        begin
            g = 8'h01;
            @(negedge ref_clk);
            while (system_clock_tick !== 1'b1 && g < 8'h64)
            begin
                @(negedge ref_clk);
                g = g + 8'h01;
            end
        end
        chk(g, exp);
    end
    endtask
    task conclude;
    begin
        $display("checks %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        #800000;
        err_total = err_total + 1;
        conclude;
    end
    initial
    begin
        err_total = 0;
        n_compared = 0;
        {rst_n, sfr_wr, sfr_rd, wake_pin, sfr_addr, sfr_wdata} = 20'h0_0000;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'hb2, 8'hc0);
        rd(8'hb3, {1'b0, TRIM});
        chk({7'h00, clk_sel_internal}, 8'h01);
        per(8'h20);
        for (d = 0; d < 4; d = d + 1)
        begin
            wr(8'hb2, 8'h9c | d[7:0]);
            rd(8'hb2, 8'hc0 | d[7:0]);
            per(8'h20 >> d);
        end
        wr(8'hb2, 8'h00);
        rd(8'hb2, 8'h00);
        chk({7'h00, osc_run}, 8'h00);
        wr(8'hb3, 8'hff);
        rd(8'hb3, 8'h7f);
        chk({1'b0, osc_trim}, 8'h7f);
        wr(8'hb3, {1'b0, TRIM});
        wr(8'hb2, 8'h80);
        rd(8'hb2, 8'h80);
        repeat (6) @(posedge ref_clk);
        rd(8'hb2, 8'hc0);
        // first pass wakes on a rising edge, second on a falling edge
        for (d = 0; d < 2; d = d + 1)
        begin
            wr(8'hb2, 8'ha0);
            rd(8'hb2, 8'ha0);
            n = 0;
            repeat (40) @(negedge ref_clk) n = n + (system_clock_tick === 1'b1);
            chk(n[7:0], 8'h00);
            @(posedge ref_clk) wake_pin <= ~wake_pin;
            repeat (8) @(posedge ref_clk);
            rd(8'hb2, 8'hc0);
            per(8'h20);
        end
        rd(8'hb4, 8'h00);
        conclude;
    end
endmodule // tb_hf_osc_control
